// file: verilog/aafm_map.svh
// Register offsets, field positions and reset values of the back end.
`ifndef AAFM_MAP_SVH
`define AAFM_MAP_SVH

`define AAFM_ADDR_W 8
`define AAFM_DATA_W 16
`define AAFM_MUX_W 7
`define AAFM_SAMPLE_W 12
`define AAFM_ACC_W 19

`define AAFM_OFF_CTRL_A 8'h00
`define AAFM_OFF_CTRL_B 8'h01
`define AAFM_OFF_MUX_POS 8'h02
`define AAFM_OFF_MUX_NEG 8'h03
`define AAFM_OFF_COMMAND 8'h04
`define AAFM_OFF_RESULT 8'h05
`define AAFM_OFF_STATUS 8'h06
`define AAFM_OFF_HOLD 8'h07

`define AAFM_CTRLA_LEFT_BIT 0
`define AAFM_CTRLA_DIFF_BIT 1
`define AAFM_CMD_GO_BIT 0
`define AAFM_STAT_BUSY_BIT 0
`define AAFM_STAT_NEW_BIT 1
`define AAFM_STAT_CNT_LSB 8

`define AAFM_CTRLB_RESET 3'h0
`define AAFM_MUX_RESET 7'h00
`define AAFM_RESULT_RESET 16'h0000
`define AAFM_TRUNC_FROM 3'h4

`endif

// file: verilog/aafm_pkg.sv
// Types shared by the accumulate and format back end.
package aafm_pkg;
  typedef enum logic {
    AAFM_IDLE,
    AAFM_RUN
  } aafm_state_t;
  typedef logic [15:0] aafm_word_t;
  typedef logic [7:0] aafm_addr_t;
  typedef logic [6:0] aafm_mux_t;
  typedef logic [11:0] aafm_sample_t;
  typedef logic [2:0] aafm_count_sel_t;
  typedef logic [18:0] aafm_acc_t;
endpackage

// file: verilog/aafm_format.sv
// Formats the accumulated sum into the 16-bit result word.
`timescale 1ns/1ps
`default_nettype none
`include "aafm_map.svh"
module aafm_format
  import aafm_pkg::*;
(
  input wire aafm_pkg::aafm_acc_t acc_i,
  input wire aafm_pkg::aafm_count_sel_t count_sel_i,
  input wire logic left_i,
  input wire logic diff_i,
  output logic [15:0] result_o
);
  wire small_cnt;
  wire [2:0] up_amt;
  wire [2:0] dn_amt;
  wire [18:0] up_val;
  wire [18:0] dn_val;
  wire [15:0] small_val;

  assign small_cnt = (count_sel_i <= `AAFM_TRUNC_FROM);
  assign up_amt = `AAFM_TRUNC_FROM - count_sel_i;
  assign dn_amt = count_sel_i - `AAFM_TRUNC_FROM;
  // Left adjust moves the widened sum so its top bit lands in bit 15.
  assign up_val = acc_i << up_amt;
  // Above 16 samples low bits are dropped; the shift keeps the sign.
  assign dn_val = diff_i ? 19'($signed(acc_i) >>> dn_amt)
                         : (acc_i >> dn_amt);
  // The accumulator is already zero or sign extended, so right adjust
  // only needs the low 16 bits.
  assign small_val = left_i ? up_val[15:0] : acc_i[15:0];
  assign result_o = small_cnt ? small_val : dn_val[15:0];
endmodule
`default_nettype wire

// file: verilog/aafm_top.sv
// Accumulate, format and channel hold logic of the converter back end.
//
// Operation
// - Right-adjust result by default, low byte LSbs.
// - Left-adjust bit moves MSbs into high byte.
// - Sum back-to-back samples, count from control B.
// - Above 16 samples, truncate LSbs to fit.
// - Single-ended widths 12..16 bits, zero fill.
// - Differential same widths, sign fill, truncated.
// - Single-ended uses positive select; differential both.
// - Channel selects pass through a holding register.
// - Idle: holding register tracks every select write.
// - Conversion running: holding register frozen.
// - Tracking resumes in the final conversion cycle.
// - Go bit write starts conversion next edge.
// - Single-ended unsigned, differential two's complement.
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "aafm_map.svh"
module aafm_top
  import aafm_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  input wire aafm_pkg::aafm_addr_t ADDR_I,
  input wire aafm_pkg::aafm_word_t WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output aafm_pkg::aafm_word_t RDATA_O,
  input wire logic SAMPLE_VALID_I,
  input wire aafm_pkg::aafm_sample_t SAMPLE_DATA_I,
  input wire logic FINAL_CYCLE_I,
  output logic SAMPLE_START_O,
  output aafm_pkg::aafm_mux_t AIN_POS_O,
  output aafm_pkg::aafm_mux_t AIN_NEG_O,
  output logic DIFF_MODE_O,
  output logic BUSY_O,
  output logic RESULT_READY_O
);
  import aafm_pkg::*;

  // Software-visible configuration.
  logic left_r;
  logic diff_r;
  aafm_count_sel_t cnt_sel_r;
  aafm_mux_t pos_r;
  aafm_mux_t neg_r;
  aafm_word_t result_r;
  logic new_r;
  logic go_r;

  // Conversion sequencing.
  aafm_state_t state_r;
  aafm_state_t state_nxt;
  aafm_acc_t acc_r;
  aafm_acc_t acc_nxt;
  logic [7:0] done_r;
  logic [7:0] done_nxt;
  aafm_count_sel_t run_sel_r;
  logic run_left_r;
  logic run_diff_r;
  logic start_r;
  logic ready_r;

  // Channel holding register and its outputs.
  aafm_mux_t hold_pos_r;
  aafm_mux_t hold_neg_r;
  aafm_word_t rdata_r;

  // Register decode.
  wire wr_ctrl_a;
  wire wr_ctrl_b;
  wire wr_pos;
  wire wr_neg;
  wire wr_cmd;
  wire rd_result;
  assign wr_ctrl_a = WR_I && (ADDR_I == `AAFM_OFF_CTRL_A);
  assign wr_ctrl_b = WR_I && (ADDR_I == `AAFM_OFF_CTRL_B);
  assign wr_pos = WR_I && (ADDR_I == `AAFM_OFF_MUX_POS);
  assign wr_neg = WR_I && (ADDR_I == `AAFM_OFF_MUX_NEG);
  assign wr_cmd = WR_I && (ADDR_I == `AAFM_OFF_COMMAND);
  assign rd_result = RD_I && (ADDR_I == `AAFM_OFF_RESULT);

  // A go write while a conversion runs is ignored; the bit is already set.
  wire go_req;
  assign go_req = wr_cmd && WDATA_I[`AAFM_CMD_GO_BIT]
                  && (state_r == AAFM_IDLE);

  // Sample extension: unsigned for single-ended, signed for differential.
  wire [6:0] ext_bits;
  wire [18:0] sample_ext;
  assign ext_bits = run_diff_r ? {7{SAMPLE_DATA_I[11]}} : 7'h00;
  assign sample_ext = {ext_bits, SAMPLE_DATA_I};

  // Number of samples to accumulate in total, as 2 to the power of the selection.
  wire [7:0] target;
  wire last_sample;
  wire finish;
  assign target = 8'(8'h01 << run_sel_r);
  assign last_sample = (done_r + 8'h01) == target;
  assign finish = (state_r == AAFM_RUN) && SAMPLE_VALID_I && last_sample;

  // Formatting sees the sum including the sample that arrives now, so the
  // result register is written in the same edge as the last addition.
  wire [15:0] fmt_result;
  aafm_format u_format (
    .acc_i(acc_nxt),
    .count_sel_i(run_sel_r),
    .left_i(run_left_r),
    .diff_i(run_diff_r),
    .result_o(fmt_result)
  );

  // The holding register tracks while idle and in the final cycle of a
  // running conversion; otherwise the sampled input must not move.
  wire hold_track;
  assign hold_track = (state_r == AAFM_IDLE) || FINAL_CYCLE_I;

  // Next-state logic of the sequencer.
  always_comb begin
    state_nxt = state_r;
    acc_nxt = acc_r;
    done_nxt = done_r;
    case (state_r)
      AAFM_IDLE: begin
        if (go_req) begin
          state_nxt = AAFM_RUN;
          acc_nxt = '0;
          done_nxt = 8'h00;
        end
      end
      AAFM_RUN: begin
        if (SAMPLE_VALID_I) begin
          acc_nxt = 19'(acc_r + sample_ext);
          done_nxt = 8'(done_r + 8'h01);
          if (last_sample) begin
            state_nxt = AAFM_IDLE;
          end
        end
      end
      default: begin
        state_nxt = AAFM_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      state_r <= AAFM_IDLE;
      acc_r <= '0;
      done_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      acc_r <= acc_nxt;
      done_r <= done_nxt;
    end
  end

  // Configuration writes. Settings are copied at the start so that a write
  // in the middle of an accumulation cannot mix two formats in one result.
  wire left_nxt;
  wire diff_nxt;
  wire [2:0] cnt_sel_nxt;
  wire [6:0] pos_nxt;
  wire [6:0] neg_nxt;
  assign left_nxt = wr_ctrl_a ? WDATA_I[`AAFM_CTRLA_LEFT_BIT]
                              : left_r;
  assign diff_nxt = wr_ctrl_a ? WDATA_I[`AAFM_CTRLA_DIFF_BIT]
                              : diff_r;
  assign cnt_sel_nxt = wr_ctrl_b ? WDATA_I[2:0] : cnt_sel_r;
  assign pos_nxt = wr_pos ? WDATA_I[6:0] : pos_r;
  assign neg_nxt = wr_neg ? WDATA_I[6:0] : neg_r;

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      left_r <= 1'b0;
      diff_r <= 1'b0;
      cnt_sel_r <= `AAFM_CTRLB_RESET;
    end else begin
      left_r <= left_nxt;
      diff_r <= diff_nxt;
      cnt_sel_r <= cnt_sel_nxt;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      pos_r <= `AAFM_MUX_RESET;
      neg_r <= `AAFM_MUX_RESET;
    end else begin
      pos_r <= pos_nxt;
      neg_r <= neg_nxt;
    end
  end

  // Copies of the settings that the running accumulation uses.
  wire [2:0] run_sel_nxt;
  wire run_left_nxt;
  wire run_diff_nxt;
  assign run_sel_nxt = go_req ? cnt_sel_r : run_sel_r;
  assign run_left_nxt = go_req ? left_r : run_left_r;
  assign run_diff_nxt = go_req ? diff_r : run_diff_r;

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      run_sel_r <= `AAFM_CTRLB_RESET;
      run_left_r <= 1'b0;
      run_diff_r <= 1'b0;
    end else begin
      run_sel_r <= run_sel_nxt;
      run_left_r <= run_left_nxt;
      run_diff_r <= run_diff_nxt;
    end
  end

  // Go bit stays set for the whole accumulation and one sample is
  // requested from the core at the start and after each returned sample but the last.
  wire go_nxt;
  wire start_nxt;
  assign go_nxt = (go_r || go_req) && !finish;
  assign start_nxt = go_req || ((state_r == AAFM_RUN) && SAMPLE_VALID_I
                                && !last_sample);

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      go_r <= 1'b0;
      start_r <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      go_r <= go_nxt;
      start_r <= start_nxt;
      ready_r <= finish;
    end
  end

  // Result is only written once the last configured sample is in. The new
  // flag is set by hardware and cleared by a read; the set wins.
  wire [15:0] result_nxt;
  wire new_nxt;
  assign result_nxt = finish ? fmt_result : result_r;
  assign new_nxt = finish || (new_r && !rd_result);

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      result_r <= `AAFM_RESULT_RESET;
      new_r <= 1'b0;
    end else begin
      result_r <= result_nxt;
      new_r <= new_nxt;
    end
  end

  // Holding register between the select registers and the multiplexer.
  // It copies the written value, so it follows a write by one cycle.
  // Tracking every idle cycle costs that lag but needs no write detect.
  wire [6:0] hold_pos_nxt;
  wire [6:0] hold_neg_nxt;
  assign hold_pos_nxt = hold_track ? pos_r : hold_pos_r;
  assign hold_neg_nxt = hold_track ? neg_r : hold_neg_r;

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      hold_pos_r <= `AAFM_MUX_RESET;
      hold_neg_r <= `AAFM_MUX_RESET;
    end else begin
      hold_pos_r <= hold_pos_nxt;
      hold_neg_r <= hold_neg_nxt;
    end
  end

  // Single-ended conversions drive no negative selection to the core.
  logic [6:0] ain_neg_r;
  logic diff_out_r;
  // During a run the latched mode decides, so a control write made
  // mid-run cannot switch the negative input under a sample.
  wire mode_diff;
  wire [6:0] ain_neg_nxt;
  assign mode_diff = (state_r == AAFM_RUN) ? run_diff_r : diff_r;
  assign ain_neg_nxt = mode_diff ? hold_neg_r : `AAFM_MUX_RESET;

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      ain_neg_r <= `AAFM_MUX_RESET;
      diff_out_r <= 1'b0;
    end else begin
      diff_out_r <= mode_diff;
      ain_neg_r <= ain_neg_nxt;
    end
  end

  // Read mux; unmapped offsets read as zero. Each offset gates its own
  // word and the words are ORed, so no priority between them is implied.
  wire [15:0] stat_word;
  wire [15:0] hold_word;
  wire [15:0] rd_mux;
  wire hit_ctrl_a;
  wire hit_ctrl_b;
  wire hit_pos;
  wire hit_neg;
  wire hit_cmd;
  wire hit_result;
  wire hit_stat;
  wire hit_hold;
  assign stat_word = {done_r, 6'h00, new_r, go_r};
  assign hold_word = {1'b0, hold_neg_r, 1'b0, hold_pos_r};
  assign hit_ctrl_a = (ADDR_I == `AAFM_OFF_CTRL_A);
  assign hit_ctrl_b = (ADDR_I == `AAFM_OFF_CTRL_B);
  assign hit_pos = (ADDR_I == `AAFM_OFF_MUX_POS);
  assign hit_neg = (ADDR_I == `AAFM_OFF_MUX_NEG);
  assign hit_cmd = (ADDR_I == `AAFM_OFF_COMMAND);
  assign hit_result = (ADDR_I == `AAFM_OFF_RESULT);
  assign hit_stat = (ADDR_I == `AAFM_OFF_STATUS);
  assign hit_hold = (ADDR_I == `AAFM_OFF_HOLD);
  assign rd_mux = ({16{hit_ctrl_a}} & {14'h0000, diff_r, left_r})
                | ({16{hit_ctrl_b}} & {13'h0000, cnt_sel_r})
                | ({16{hit_pos}} & {9'h000, pos_r})
                | ({16{hit_neg}} & {9'h000, neg_r})
                | ({16{hit_cmd}} & {15'h0000, go_r})
                | ({16{hit_result}} & result_r)
                | ({16{hit_stat}} & stat_word)
                | ({16{hit_hold}} & hold_word);

  // Read data stands only in the cycle after the strobe.
  // Zero outside the answer cycle lets a host OR several read buses.
  wire [15:0] rdata_nxt;
  assign rdata_nxt = RD_I ? rd_mux : 16'h0000;
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign RDATA_O = rdata_r;
  assign SAMPLE_START_O = start_r;
  assign AIN_POS_O = hold_pos_r;
  assign AIN_NEG_O = ain_neg_r;
  assign DIFF_MODE_O = diff_out_r;
  assign BUSY_O = go_r;
  assign RESULT_READY_O = ready_r;
endmodule
`default_nettype wire

// file: testbench/aafm_chk_sva.sv
// Concurrent port checks for the converter back end.
`timescale 1ns/1ps
`default_nettype none
module aafm_chk
  import aafm_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  input wire aafm_pkg::aafm_addr_t ADDR_I,
  input wire aafm_pkg::aafm_word_t WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire aafm_pkg::aafm_word_t RDATA_O,
  input wire logic SAMPLE_VALID_I,
  input wire aafm_pkg::aafm_sample_t SAMPLE_DATA_I,
  input wire logic FINAL_CYCLE_I,
  input wire logic SAMPLE_START_O,
  input wire aafm_pkg::aafm_mux_t AIN_POS_O,
  input wire aafm_pkg::aafm_mux_t AIN_NEG_O,
  input wire logic DIFF_MODE_O,
  input wire logic BUSY_O,
  input wire logic RESULT_READY_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);
  sequence go_wr;
    WR_I && ADDR_I == 8'h04 && WDATA_I[0] && !BUSY_O;
  endsequence
  sequence sample_in;
    SAMPLE_VALID_I && BUSY_O;
  endsequence
  a_go_starts: assert property (go_wr |=> BUSY_O && SAMPLE_START_O)
    else $error("Go write did not start a sample.");
  a_sample_next: assert property (
    sample_in |=> SAMPLE_START_O || RESULT_READY_O)
    else $error("Sample was not followed by a start or a result.");
  a_start_pulse: assert property (
    SAMPLE_START_O |-> BUSY_O ##1 !SAMPLE_START_O)
    else $error("Start pulse outside a run or too long.");
  a_ready_pulse: assert property (
    RESULT_READY_O |-> !BUSY_O && $past(SAMPLE_VALID_I) ##1 !RESULT_READY_O)
    else $error("Result ready without a closing sample.");
  a_busy_end: assert property ($fell(BUSY_O) |-> RESULT_READY_O)
    else $error("Run ended without a result.");
  a_se_neg_zero: assert property (!DIFF_MODE_O |-> AIN_NEG_O == 7'h00)
    else $error("Negative input used in single-ended mode.");
  a_hold_frozen: assert property (
    BUSY_O && $past(BUSY_O) && $past(BUSY_O, 2) && !$past(FINAL_CYCLE_I) &&
    !$past(FINAL_CYCLE_I, 2) && !$past(FINAL_CYCLE_I, 3) |-> $stable(AIN_POS_O))
    else $error("Positive input moved during a conversion.");
  a_rd_idle: assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
    else $error("Read data outside the read answer cycle.");
  a_reset_zero: assert property (
    $past(SYS_RST_I) |-> !BUSY_O && !SAMPLE_START_O && AIN_POS_O == 7'h00)
    else $error("Outputs not cleared by reset.");
endmodule
bind aafm_top aafm_chk u_chk (.CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .SAMPLE_VALID_I(SAMPLE_VALID_I),
  .SAMPLE_DATA_I(SAMPLE_DATA_I), .FINAL_CYCLE_I(FINAL_CYCLE_I),
  .SAMPLE_START_O(SAMPLE_START_O), .AIN_POS_O(AIN_POS_O),
  .AIN_NEG_O(AIN_NEG_O), .DIFF_MODE_O(DIFF_MODE_O), .BUSY_O(BUSY_O),
  .RESULT_READY_O(RESULT_READY_O));
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the accumulate and format back end.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import aafm_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, vld = 0, fin = 0, rd_q = 0;
  logic start, diffm, busy, rdy;
  aafm_addr_t adr = '0;
  aafm_word_t wd = '0, rdata, q[$];
  aafm_sample_t smp = '0;
  aafm_mux_t apos, aneg;
  int errors = 0, n_checks = 0;
  integer seed = 32'h607A36A1;
  aafm_top DUT (.CLOCK_I(clk), .SYS_RST_I(rst), .ADDR_I(adr), .WDATA_I(wd),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .SAMPLE_VALID_I(vld),
    .SAMPLE_DATA_I(smp), .FINAL_CYCLE_I(fin), .SAMPLE_START_O(start),
    .AIN_POS_O(apos), .AIN_NEG_O(aneg), .DIFF_MODE_O(diffm), .BUSY_O(busy),
    .RESULT_READY_O(rdy));
  initial forever #12.5 clk = ~clk;
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string n, aafm_word_t e, aafm_word_t g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Read answers are matched in order against the notes queued by rdx.
  always @(posedge clk) begin
    rd_q <= rd;
    if (rd_q)
      chk("rdata", q.pop_front(), rdata);
  end
  task automatic wrt(aafm_addr_t a, aafm_word_t d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdx(aafm_addr_t a, aafm_word_t e);
    @(posedge clk);
    adr <= a;
    rd <= 1'b1;
    q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic feed(aafm_sample_t s);
    @(posedge clk);
    vld <= 1'b1;
    smp <= s;
    @(posedge clk);
    vld <= 1'b0;
  endtask
  task automatic wstart;
    int k;
    k = 0;
    while (start !== 1'b1 && k < 50) begin
      @(posedge clk);
      k++;
    end
    if (k == 50)
      chk("start", 16'h0001, 16'h0000);
  endtask
  // Mode bits: m[0] left adjust, m[1] differential, m[4:2] count select.
  task automatic run(logic [4:0] m);
    aafm_acc_t acc;
    aafm_word_t e;
    aafm_sample_t s;
    int k;
    acc = '0;
    wrt(8'h00, {14'h0000, m[1:0]});
    wrt(8'h01, {13'h0000, m[4:2]});
    wrt(8'h04, 16'h0001);
    repeat (1 << m[4:2]) begin
      wstart();
      s = aafm_sample_t'($random(seed));
      acc = acc + (m[1] ? {{7{s[11]}}, s} : {7'h00, s});
      feed(s);
    end
    k = m[4:2] > 4 ? m[4:2] - 4 : 0;
    if (m[1])
      acc = $signed(acc) >>> k;
    else
      acc = acc >> k;
    e = (m[0] && m[4:2] < 4) ? acc[15:0] << (4 - m[4:2]) : acc[15:0];
    rdx(8'h05, e);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdx(8'h05, 16'h0000);
    wrt(8'h05, 16'hFFFF);
    rdx(8'h05, 16'h0000);
    rdx(8'h20, 16'h0000);
    $display("test registers done");
    wrt(8'h02, 16'h0015);
    wrt(8'h03, 16'h002A);
    wrt(8'h00, 16'h0002);
    wrt(8'h01, 16'h0000);
    repeat (4) @(posedge clk);
    rdx(8'h07, 16'h2A15);
    rdx(8'h00, 16'h0002);
    rdx(8'h01, 16'h0000);
    wrt(8'h04, 16'h0001);
    wrt(8'h02, 16'h0033);
    repeat (3) @(posedge clk);
    chk("pos", 16'h0015, {9'h000, apos});
    chk("neg", 16'h002A, {9'h000, aneg});
    chk("diff", 16'h0001, {15'h0000, diffm});
    rdx(8'h04, 16'h0001);
    rdx(8'h07, 16'h2A15);
    @(posedge clk);
    fin <= 1'b1;
    @(posedge clk);
    fin <= 1'b0;
    repeat (3) @(posedge clk);
    chk("pos", 16'h0033, {9'h000, apos});
    rdx(8'h07, 16'h2A33);
    feed(12'h800);
    rdx(8'h06, 16'h0102);
    rdx(8'h05, 16'hF800);
    rdx(8'h06, 16'h0100);
    $display("test channel hold done");
    for (int m = 0; m < 32; m++)
      run(m[4:0]);
    $display("test accumulate done");
    repeat (4) @(posedge clk);
    end_sim();
  end
  // The full run needs about 3400 cycles; this limit leaves ample margin.
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    end_sim();
  end
endmodule
`default_nettype wire
